// ---- hw/dtc_defines.vh ----
`ifndef DTC_DEFINES_VH
`define DTC_DEFINES_VH
// bandwidth codes, ordered so that compare gives wider/narrower
`define DTC_BW_NB 2'h0
`define DTC_BW_WB 2'h1
`define DTC_BW_SWB 2'h2
`define DTC_BW_FB 2'h3
// coder types
`define DTC_CT_AUDIO 3'h4
`define DTC_CT_INACTIVE 3'h0
// core types
`define DTC_CORE_ACELP 2'h0
`define DTC_CORE_MDCT 2'h1
// counter limits and reset values
`define DTC_UP_LIMIT 6'h14
`define DTC_DOWN_LIMIT 6'h28
`define DTC_UP_INIT 6'h14
`define DTC_DOWN_INIT 6'h28
// bit rates in bits per second, DTC_FS_MIN a sampling rate in samples per second
`define DTC_RATE_9K6 16'h2580
`define DTC_RATE_16K4 16'h4010
`define DTC_RATE_24K4 16'h5F50
`define DTC_CORE_MIN 16'h0960
`define DTC_FS_MIN 17'h07D00
// upper-band schemes
`define DTC_UB_NONE 2'h0
`define DTC_UB_TIME 2'h1
`define DTC_UB_FREQ 2'h2
`define DTC_UB_MDCT 2'h3
// sequencer state width
`define DTC_ST_W 2
`endif

// ---- hw/dtc_bw_counters.v ----
`include "dtc_defines.vh"
// bandwidth switch detector: both counters, updated once per frame
module dtc_bw_counters (
  // clock and reset
  input wire ref_clk,
  input wire reset,
  // frame update strobe
  input wire update,
  // frame descriptors
  input wire [15:0] bitRate,
  input wire [15:0] prevBitRate,
  input wire [1:0] bandwidth,
  input wire [1:0] prevBandwidth,
  // counters
  output reg [5:0] upward_switch_counter_reg,
  output reg [5:0] downward_switch_counter_reg
);
  reg [5:0] upNext;
  reg [5:0] downNext;
  reg [5:0] upMid;
  reg [5:0] downMid;
  wire bwDown = bandwidth < prevBandwidth;
  wire bwUp = bandwidth > prevBandwidth;

  always @* begin
    upMid = upward_switch_counter_reg;
    downMid = downward_switch_counter_reg;
    // upward counter first
    if (upMid >= `DTC_UP_LIMIT) begin
      upMid = 6'h00; // see RULE_15
    end else if (bandwidth == `DTC_BW_SWB && bitRate > `DTC_RATE_9K6 &&
        prevBandwidth == `DTC_BW_WB && prevBitRate <= `DTC_RATE_9K6) begin
      upMid = upMid + 6'h01; // see RULE_15
    end else if (upMid != 6'h00) begin
      if (bwDown) begin
        downMid = (`DTC_UP_LIMIT - upMid) * 6'h02 - 6'h01; // see RULE_16
        upMid = 6'h00;
      end else begin
        upMid = (bandwidth == `DTC_BW_SWB) ? upMid + 6'h01 : 6'h00;
        downMid = 6'h00; // see RULE_16
      end
    end
    upNext = upMid;
    downNext = downMid;
    // then downward counter, on updated values
    if (downMid >= `DTC_DOWN_LIMIT) begin
      downNext = 6'h00; // see RULE_17
    end else if (bitRate <= `DTC_RATE_9K6 && prevBitRate > `DTC_RATE_9K6 &&
        bwDown && bandwidth == `DTC_BW_WB) begin
      downNext = downMid + 6'h01; // see RULE_17
    end else if (downMid != 6'h00) begin
      if (bwUp) begin
        downNext = 6'h00;
        upNext = (`DTC_DOWN_LIMIT - downMid) >> 1; // see RULE_18
      end else begin
        downNext = (bandwidth == `DTC_BW_WB) ? downMid + 6'h01 : 6'h00;
        upNext = 6'h00; // see RULE_18
      end
    end
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      upward_switch_counter_reg <= `DTC_UP_INIT; // see RULE_14
      downward_switch_counter_reg <= `DTC_DOWN_INIT; // see RULE_14
    end else if (update) begin
      upward_switch_counter_reg <= upNext; // see RULE_23
      downward_switch_counter_reg <= downNext;
    end
  end
endmodule // dtc_bw_counters

// ---- hw/dtc_transition_ctrl.v ----
// Operation
// RULE_01 - rate switch with filter on: resample memories
// RULE_02 - filter previously off: stay off, prime memories
// RULE_03 - filter turned off: smooth first subframe
// RULE_04 - resample past samples on internal rate switch
// RULE_05 - resynthesize residual; later subframes untouched
// RULE_06 - clear bass filter memory at three rates
// RULE_07 - resample filterbank states on internal switch
// RULE_08 - entering legacy mode clears improvement memories
// RULE_09 - first legacy frame: both post-filters off
// RULE_10 - bit-rate change reconfigures tools at start
// RULE_11 - sampling-rate steps precede coding-mode steps
// RULE_12 - smoothing resamples only on internal switch
// RULE_13 - smooth upward, blind extension downward
// RULE_14 - counters initialize to 20 and 40
// RULE_15 - upward counter clear or increment rule
// RULE_16 - upward nonzero: update both counters
// RULE_17 - downward counter clear or increment rule
// RULE_18 - downward nonzero: update both counters
// RULE_19 - nonzero counters report transitions
// RULE_20 - conditions selecting time-domain extension
// RULE_21 - conditions selecting frequency-domain extension
// RULE_22 - MDCT core downward: predict upper coefficients
// RULE_23 - counters first, then scheme; held per frame
// RULE_24 - core presents frame descriptors before decision
`include "dtc_defines.vh"
module dtc_transition_ctrl (
  // clock and reset
  input wire ref_clk,
  input wire reset,
  // frame tick from decoder core
  input wire frameStart,
  // current frame descriptors
  input wire [15:0] bitRate,
  input wire [15:0] coreBitRate,
  input wire [1:0] bandwidth,
  input wire [1:0] coreType,
  input wire [2:0] coder_type,
  input wire [16:0] output_sample_rate,
  input wire pppMode,
  input wire legacy_interop_mode,
  input wire postFilterOn,
  input wire [2:0] internalRate,
  input wire [2:0] sampleRate,
  input wire [1:0] codingMode,
  // previous frame descriptors
  input wire [15:0] prevBitRate,
  input wire [1:0] prevBandwidth,
  input wire prevLegacyMode,
  input wire prevPostFilterOn,
  input wire [2:0] prevInternalRate,
  input wire [2:0] prevSampleRate,
  input wire [1:0] prevCodingMode,
  // memory handling commands
  output reg resamplePostFilterMem,
  output reg postFilterEnable,
  output reg postFilterPrime,
  output reg smoothFirstSubframe,
  output reg resamplePastSamples,
  output reg clearBassMem,
  output reg resampleFilterbank,
  output reg clearLegacyMem,
  output reg bassFilterEnable,
  output reg reconfigureTools,
  output reg rateSwitchStep,
  output reg modeSwitchStep,
  // bandwidth switching
  output reg upSwitchActive,
  output reg downSwitchActive,
  output reg upwardSmoothing,
  output reg blindExtension,
  output reg [1:0] upperBandScheme,
  output reg [5:0] upCount,
  output reg [5:0] downCount,
  output reg decisionValid
);
  localparam ST_IDLE = 2'h0;
  localparam ST_RATE = 2'h1;
  localparam ST_MODE = 2'h2;
  localparam ST_DONE = 2'h3;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  wire [5:0] upCnt;
  wire [5:0] downCnt;
  wire cntUpdate = (state_reg == ST_IDLE) && frameStart;

  function isBassRate;
    input [15:0] r;
    begin
      isBassRate = (r == `DTC_RATE_9K6) || (r == `DTC_RATE_16K4) ||
        (r == `DTC_RATE_24K4);
    end
  endfunction

  dtc_bw_counters counters (
    .ref_clk(ref_clk),
    .reset(reset),
    .update(cntUpdate),
    .bitRate(bitRate),
    .prevBitRate(prevBitRate),
    .bandwidth(bandwidth),
    .prevBandwidth(prevBandwidth),
    .upward_switch_counter_reg(upCnt),
    .downward_switch_counter_reg(downCnt)
  );

  // frame descriptors latched at frame start
  reg fsSwitch_reg, isSwitch_reg, rateChg_reg, modeChg_reg;
  reg pfOn_reg, pfPrev_reg, legacy_reg, legacyPrev_reg, bass_reg;
  reg [15:0] coreRate_reg;
  reg [1:0] bw_reg, core_reg;
  reg [2:0] ct_reg;
  reg [16:0] fs_reg;
  reg ppp_reg;

  always @(posedge ref_clk) begin
    if (reset) begin
      fsSwitch_reg <= 1'b0;
      isSwitch_reg <= 1'b0;
      rateChg_reg <= 1'b0;
      modeChg_reg <= 1'b0;
      pfOn_reg <= 1'b0;
      pfPrev_reg <= 1'b0;
      legacy_reg <= 1'b0;
      legacyPrev_reg <= 1'b0;
      bass_reg <= 1'b0;
      coreRate_reg <= 16'h0000;
      bw_reg <= `DTC_BW_NB;
      core_reg <= `DTC_CORE_ACELP;
      ct_reg <= `DTC_CT_INACTIVE;
      fs_reg <= 17'h00000;
      ppp_reg <= 1'b0;
    end else if (cntUpdate) begin // see RULE_24
      fsSwitch_reg <= sampleRate != prevSampleRate;
      isSwitch_reg <= internalRate != prevInternalRate;
      rateChg_reg <= bitRate != prevBitRate;
      modeChg_reg <= codingMode != prevCodingMode;
      pfOn_reg <= postFilterOn;
      pfPrev_reg <= prevPostFilterOn;
      legacy_reg <= legacy_interop_mode;
      legacyPrev_reg <= prevLegacyMode;
      bass_reg <= isBassRate(bitRate);
      coreRate_reg <= coreBitRate;
      bw_reg <= bandwidth;
      core_reg <= coreType;
      ct_reg <= coder_type;
      fs_reg <= output_sample_rate;
      ppp_reg <= pppMode;
    end
  end

  // sequencer: latch, rate-switch step, mode-switch step, publish
  always @* begin
    case (state_reg)
      ST_IDLE: state_next = frameStart ? ST_RATE : ST_IDLE;
      ST_RATE: state_next = ST_MODE; // see RULE_11
      ST_MODE: state_next = ST_DONE;
      ST_DONE: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  wire commonUb = (core_reg == `DTC_CORE_ACELP) && (fs_reg >= `DTC_FS_MIN) &&
    (bw_reg > `DTC_BW_NB) && (downCnt != 6'h00);
  wire timeUb = (ct_reg != `DTC_CT_AUDIO) && (ct_reg != `DTC_CT_INACTIVE) &&
    (coreRate_reg > `DTC_CORE_MIN) && commonUb && !ppp_reg;
  wire firstLegacy = legacy_reg && !legacyPrev_reg;
  wire pfSmooth = pfPrev_reg && !pfOn_reg;

  always @(posedge ref_clk) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      resamplePostFilterMem <= 1'b0;
      postFilterEnable <= 1'b0;
      postFilterPrime <= 1'b0;
      smoothFirstSubframe <= 1'b0;
      resamplePastSamples <= 1'b0;
      clearBassMem <= 1'b0;
      resampleFilterbank <= 1'b0;
      clearLegacyMem <= 1'b0;
      bassFilterEnable <= 1'b0;
      reconfigureTools <= 1'b0;
      rateSwitchStep <= 1'b0;
      modeSwitchStep <= 1'b0;
      upSwitchActive <= 1'b0;
      downSwitchActive <= 1'b0;
      upwardSmoothing <= 1'b0;
      blindExtension <= 1'b0;
      upperBandScheme <= `DTC_UB_NONE;
      upCount <= `DTC_UP_INIT;
      downCount <= `DTC_DOWN_INIT;
      decisionValid <= 1'b0;
    end else begin
      state_reg <= state_next;
      rateSwitchStep <= state_reg == ST_RATE && isSwitch_reg; // see RULE_11
      modeSwitchStep <= state_reg == ST_MODE && modeChg_reg; // see RULE_11
      reconfigureTools <= state_reg == ST_RATE && rateChg_reg; // see RULE_10
      decisionValid <= state_reg == ST_DONE;
      if (state_reg == ST_DONE) begin // see RULE_23
        resamplePostFilterMem <= fsSwitch_reg && pfPrev_reg; // see RULE_01
        postFilterEnable <= pfOn_reg && (pfPrev_reg || !fsSwitch_reg) &&
          !firstLegacy; // see RULE_02
        postFilterPrime <= fsSwitch_reg && !pfPrev_reg; // see RULE_02
        smoothFirstSubframe <= pfSmooth; // see RULE_03
        resamplePastSamples <= pfSmooth && isSwitch_reg; // see RULE_04 RULE_12
        clearBassMem <= fsSwitch_reg && bass_reg; // see RULE_06
        resampleFilterbank <= isSwitch_reg; // see RULE_07
        clearLegacyMem <= firstLegacy; // see RULE_08
        bassFilterEnable <= !firstLegacy &&
          !(fsSwitch_reg && bass_reg); // see RULE_09
        upSwitchActive <= upCnt != 6'h00; // see RULE_19
        downSwitchActive <= downCnt != 6'h00; // see RULE_19
        upwardSmoothing <= upCnt != 6'h00; // see RULE_13
        blindExtension <= downCnt != 6'h00; // see RULE_13
        upCount <= upCnt;
        downCount <= downCnt;
        if (timeUb) begin
          upperBandScheme <= `DTC_UB_TIME; // see RULE_20
        end else if (commonUb && ppp_reg) begin
          upperBandScheme <= `DTC_UB_FREQ; // see RULE_21
        end else if (core_reg == `DTC_CORE_MDCT && downCnt != 6'h00) begin
          upperBandScheme <= `DTC_UB_MDCT; // see RULE_22
        end else begin
          upperBandScheme <= `DTC_UB_NONE;
        end
      end else if (state_reg == ST_IDLE && frameStart) begin
        smoothFirstSubframe <= 1'b0; // see RULE_05
      end
    end
  end
endmodule // dtc_transition_ctrl

// ---- dv/dtc_transition_ctrl_props.sv ----
`include "dtc_defines.vh"
module dtc_tc_props (
  // clock and reset
  input logic ref_clk,
  input logic reset,
  // frame inputs
  input logic frameStart,
  input logic [15:0] bitRate,
  input logic [15:0] prevBitRate,
  input logic [2:0] internalRate,
  input logic [2:0] prevInternalRate,
  input logic [2:0] sampleRate,
  input logic [2:0] prevSampleRate,
  input logic [1:0] codingMode,
  input logic [1:0] prevCodingMode,
  input logic legacy_interop_mode,
  input logic prevLegacyMode,
  // watched outputs
  input logic reconfigureTools,
  input logic rateSwitchStep,
  input logic modeSwitchStep,
  input logic clearBassMem,
  input logic clearLegacyMem,
  input logic bassFilterEnable,
  input logic upSwitchActive,
  input logic downSwitchActive,
  input logic [5:0] upCount,
  input logic [5:0] downCount,
  input logic decisionValid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence s_both_switch;
    frameStart && internalRate != prevInternalRate
      && codingMode != prevCodingMode;
  endsequence
  sequence s_rate_then_mode;
    ##2 rateSwitchStep ##1 modeSwitchStep;
  endsequence
  valid_timing_a: assert property (frameStart |->
    ##1 !decisionValid [*3] ##1 decisionValid) else $error("late decision");
  reconfig_rate_a: assert property (frameStart |->
    ##2 reconfigureTools == $past(bitRate != prevBitRate, 2))
    else $error("reconfigure pulse wrong");
  rate_mode_order_a: assert property (
    s_both_switch |-> s_rate_then_mode)
    else $error("switch steps out of order");
  bass_clear_a: assert property (frameStart && sampleRate != prevSampleRate
    && bitRate == `DTC_RATE_9K6 |-> ##4 clearBassMem)
    else $error("bass memory kept");
  legacy_first_a: assert property (
    frameStart && legacy_interop_mode
    && !prevLegacyMode |-> ##4 clearLegacyMem && !bassFilterEnable)
    else $error("legacy entry not handled");
  up_report_a: assert property (decisionValid |->
    upSwitchActive == (upCount != 6'h00)) else $error("upward flag wrong");
  down_report_a: assert property (decisionValid |->
    downSwitchActive == (downCount != 6'h00))
    else $error("downward flag wrong");
  count_range_a: assert property (decisionValid |->
    upCount <= `DTC_UP_LIMIT && downCount <= `DTC_DOWN_LIMIT)
    else $error("counter out of range");
endmodule // dtc_tc_props
bind dtc_transition_ctrl dtc_tc_props props_u (.ref_clk(ref_clk),
  .reset(reset), .frameStart(frameStart), .bitRate(bitRate),
  .prevBitRate(prevBitRate), .internalRate(internalRate),
  .prevInternalRate(prevInternalRate), .sampleRate(sampleRate),
  .prevSampleRate(prevSampleRate), .codingMode(codingMode),
  .prevCodingMode(prevCodingMode), .prevLegacyMode(prevLegacyMode),
  .legacy_interop_mode(legacy_interop_mode), .clearBassMem(clearBassMem),
  .reconfigureTools(reconfigureTools), .rateSwitchStep(rateSwitchStep),
  .modeSwitchStep(modeSwitchStep), .clearLegacyMem(clearLegacyMem),
  .bassFilterEnable(bassFilterEnable), .upSwitchActive(upSwitchActive),
  .downSwitchActive(downSwitchActive), .upCount(upCount),
  .downCount(downCount), .decisionValid(decisionValid));

// ---- dv/dtc_core_model.sv ----
module dtc_core_model (
  // clock and reset
  input logic ref_clk,
  input logic reset,
  // current frame
  input logic frameStart,
  input logic [15:0] bitRate,
  input logic [1:0] bandwidth,
  input logic legacy_interop_mode,
  input logic postFilterOn,
  input logic [2:0] internalRate,
  input logic [1:0] codingMode,
  // previous frame
  output logic [15:0] prevBitRate,
  output logic [1:0] prevBandwidth,
  output logic prevLegacyMode,
  output logic prevPostFilterOn,
  output logic [2:0] prevInternalRate,
  output logic [1:0] prevCodingMode
);
  timeunit 1ns;
  timeprecision 1ps;
  // old values stay valid through the taking edge
  always @(posedge ref_clk) begin
    if (reset) begin
      {prevBitRate, prevBandwidth, prevLegacyMode, prevPostFilterOn,
        prevInternalRate, prevCodingMode} <= '0;
    end else if (frameStart) begin
      {prevBitRate, prevBandwidth, prevLegacyMode, prevPostFilterOn,
        prevInternalRate, prevCodingMode} <= {bitRate, bandwidth,
        legacy_interop_mode, postFilterOn, internalRate, codingMode};
    end
  end
endmodule // dtc_core_model

// ---- dv/dtc_transition_ctrl_tb_top.sv ----
`include "dtc_defines.vh"
module dtc_transition_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, reset = 1'b1, frameStart = 1'b0, pppMode = 1'b0;
  logic legacy_interop_mode = 1'b0, postFilterOn = 1'b0;
  logic [15:0] bitRate = 16'h0000, prevBitRate, pBr = 16'h0000;
  logic [1:0] bandwidth = 2'h0, coreType = 2'h0, codingMode = 2'h0;
  logic [1:0] prevBandwidth, prevCodingMode, upperBandScheme, pBw = 2'h0;
  logic [2:0] internalRate = 3'h0, prevInternalRate;
  logic prevLegacyMode, prevPostFilterOn, resamplePostFilterMem;
  logic postFilterEnable, postFilterPrime, smoothFirstSubframe;
  logic resamplePastSamples, clearBassMem, resampleFilterbank;
  logic clearLegacyMem, bassFilterEnable, reconfigureTools;
  logic rateSwitchStep, modeSwitchStep, upSwitchActive, downSwitchActive;
  logic upwardSmoothing, blindExtension, decisionValid;
  logic [5:0] upCount, downCount, expUp = 6'h14, expDown = 6'h28;
  int errors = 0, n_compared = 0;
  always #20 ref_clk = ~ref_clk;
  dtc_core_model core_u (.ref_clk, .reset, .frameStart, .bitRate,
    .bandwidth, .legacy_interop_mode, .postFilterOn, .internalRate,
    .codingMode, .prevBitRate, .prevBandwidth, .prevLegacyMode,
    .prevPostFilterOn, .prevInternalRate, .prevCodingMode);
  dtc_transition_ctrl dut_u (.ref_clk, .reset, .frameStart, .bitRate,
    .coreBitRate(bitRate), .bandwidth, .coreType, .coder_type(3'h1),
    .output_sample_rate(`DTC_FS_MIN), .pppMode, .legacy_interop_mode,
    .postFilterOn, .internalRate, .sampleRate(internalRate), .codingMode,
    .prevBitRate, .prevBandwidth, .prevLegacyMode, .prevPostFilterOn,
    .prevInternalRate, .prevSampleRate(prevInternalRate), .prevCodingMode,
    .resamplePostFilterMem, .postFilterEnable, .postFilterPrime,
    .smoothFirstSubframe, .resamplePastSamples, .clearBassMem,
    .resampleFilterbank, .clearLegacyMem, .bassFilterEnable,
    .reconfigureTools, .rateSwitchStep, .modeSwitchStep, .upSwitchActive,
    .downSwitchActive, .upwardSmoothing, .blindExtension,
    .upperBandScheme, .upCount, .downCount, .decisionValid);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // f holds pitch mode, legacy, post-filter on, mdct core
  task automatic frame(input logic [15:0] br, input logic [1:0] bw,
    input logic [2:0] ir, input logic [1:0] cm, input logic [3:0] f);
    int k;
    logic [1:0] sch;
    @(posedge ref_clk);
    {bitRate, bandwidth, internalRate, codingMode} <= {br, bw, ir, cm};
    {pppMode, legacy_interop_mode, postFilterOn} <= f[3:1];
    coreType <= {1'b0, f[0]};
    frameStart <= 1'b1;
    @(posedge ref_clk);
    frameStart <= 1'b0;
    for (k = 0; k < 8 && decisionValid !== 1'b1; k++) begin
      @(posedge ref_clk);
      #1;
    end
    if (k == 8) begin
      errors++;
      summarize();
    end
    // reference counters, upward rule first
    if (expUp >= `DTC_UP_LIMIT) expUp = 6'h00;
    else if (bw == 2'h2 && br > 16'h2580 && pBw == 2'h1 && pBr <= 16'h2580)
      expUp++;
    else if (expUp != 6'h00) begin
      expDown = (bw < pBw) ? 6'h27 - {expUp[4:0], 1'b0} : 6'h00;
      expUp = (bw < pBw || bw != 2'h2) ? 6'h00 : expUp + 6'h01;
    end
    if (expDown >= `DTC_DOWN_LIMIT) expDown = 6'h00;
    else if (br <= 16'h2580 && pBr > 16'h2580 && bw < pBw && bw == 2'h1)
      expDown++;
    else if (expDown != 6'h00) begin
      expUp = (bw > pBw) ? (6'h28 - expDown) >> 1 : 6'h00;
      expDown = (bw > pBw || bw != 2'h1) ? 6'h00 : expDown + 6'h01;
    end
    sch = `DTC_UB_NONE;
    if (!f[0] && bw > 2'h0 && expDown != 6'h00)
      sch = f[3] ? `DTC_UB_FREQ : `DTC_UB_TIME;
    else if (f[0] && expDown != 6'h00) sch = `DTC_UB_MDCT;
    check(upCount, expUp);
    check(downCount, expDown);
    check(upperBandScheme, sch);
    check(upwardSmoothing, expUp != 6'h00);
    check(blindExtension, expDown != 6'h00);
    check(upSwitchActive, expUp != 6'h00);
    check(downSwitchActive, expDown != 6'h00);
    pBr = br;
    pBw = bw;
  endtask
  task automatic t_reset;
    check(upCount, `DTC_UP_INIT);
    check(downCount, `DTC_DOWN_INIT);
    $display("test reset done");
  endtask
  task automatic t_bandwidth;
    frame(16'h2580, 2'h1, 3'h0, 2'h0, 4'h0);
    repeat (23) frame(16'h3390, 2'h2, 3'h0, 2'h0, 4'h0);
    frame(16'h2580, 2'h1, 3'h0, 2'h0, 4'h0);
    repeat (4) frame(16'h3390, 2'h2, 3'h0, 2'h0, 4'h0);
    repeat (3) frame(16'h1F40, 2'h1, 3'h0, 2'h0, 4'h0);
    frame(16'h1F40, 2'h1, 3'h0, 2'h0, 4'h8);
    frame(16'h1F40, 2'h1, 3'h0, 2'h0, 4'h1);
    frame(16'h3390, 2'h2, 3'h0, 2'h0, 4'h0);
    frame(16'h1F40, 2'h1, 3'h0, 2'h0, 4'h0);
    repeat (41) frame(16'h1F40, 2'h1, 3'h0, 2'h0, 4'h0);
    $display("test bandwidth done");
  endtask
  task automatic t_switch;
    frame(16'h2580, 2'h1, 3'h0, 2'h0, 4'h2);
    frame(16'h2580, 2'h1, 3'h1, 2'h1, 4'h2);
    check(resamplePostFilterMem, 1'b1);
    check(resampleFilterbank, 1'b1);
    check(clearBassMem, 1'b1);
    frame(16'h3390, 2'h1, 3'h1, 2'h1, 4'h0);
    check(smoothFirstSubframe, 1'b1);
    check(resamplePastSamples, 1'b0);
    check(clearBassMem, 1'b0);
    frame(16'h3390, 2'h1, 3'h2, 2'h1, 4'h2);
    check(postFilterEnable, 1'b0);
    check(postFilterPrime, 1'b1);
    frame(16'h3390, 2'h1, 3'h1, 2'h0, 4'h0);
    check(resamplePastSamples, 1'b1);
    $display("test switch done");
  endtask
  task automatic t_legacy;
    frame(16'h3390, 2'h1, 3'h1, 2'h0, 4'h6);
    check(clearLegacyMem, 1'b1);
    check(bassFilterEnable, 1'b0);
    check(postFilterEnable, 1'b0);
    frame(16'h3390, 2'h1, 3'h1, 2'h0, 4'h6);
    check(clearLegacyMem, 1'b0);
    $display("test legacy done");
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    #1;
    t_reset();
    t_bandwidth();
    t_switch();
    t_legacy();
    summarize();
  end
endmodule // dtc_transition_ctrl_tb_top
